/* File: rtl/cei_pkg.sv */
package cei_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int unsigned NUM_CMP = 2;
  localparam int unsigned ADDR_W = 4;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_FLAG = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_MASK = 4'hc;

  // ****************************************
  // Control register layout, per comparator one byte
  // ****************************************
  localparam int unsigned CTL_STRIDE = 8;
  localparam int unsigned BIT_ON = 0;
  localparam int unsigned BIT_POL = 1;
  localparam int unsigned BIT_RISE = 2;
  localparam int unsigned BIT_FALL = 3;
  localparam int unsigned BIT_IE = 4;
  // Global bits sit above the comparator bytes
  localparam int unsigned BIT_PERIPHERAL_IRQ_ENABLE = 16;
  localparam int unsigned BIT_GIE = 17;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [NUM_CMP-1:0] FLAG_RST = 2'h0;
  localparam logic [NUM_CMP-1:0] MASK_RST = 2'h0;

endpackage

/* File: rtl/cei_comparator_edge_interrupt.sv */
`timescale 1ns/1ps

// Operation
// R1: Each comparator has separate rising and falling edge detectors on its result.
// R2: Flag sets on rising edge with rise enable, or falling edge with fall enable.
// R3: Request reaches processor only with on, own, peripheral, global and an edge enable.
// R4: Flag stays set until software clears it; hardware never clears it.
// R5: Edge in the same cycle as software clear wins; flag stays set.
// R6: Polarity or on/off toggles change detected output, even when disabled; here off forces output low, so a polarity toggle while off changes nothing.
// R7: Edge is synchronized result versus its previous registered value, one-cycle pulse.
module cei_comparator_edge_interrupt
  import cei_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [NUM_CMP-1:0] cmp_raw,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [NUM_CMP-1:0] cmp_out,
  output logic cmp_irq_req,
  output logic irq
);

  // ****************************************
  // Bus decode
  // ****************************************
  logic ack_q;
  logic [31:0] ctrl_q;
  logic [NUM_CMP-1:0] flag_q;
  logic [NUM_CMP-1:0] status_q;
  logic [NUM_CMP-1:0] mask_q;
  logic [31:0] rdata_q;

  // One wait cycle per access keeps read data registered
  wire req = (avs_read | avs_write) & clk_en;
  wire take = req & ack_q;
  wire wr = take & avs_write;
  wire rd = take & avs_read;
  wire sel_ctrl = avs_address == OFS_CTRL;
  wire sel_flag = avs_address == OFS_FLAG;
  wire sel_status = avs_address == OFS_STATUS;
  wire sel_mask = avs_address == OFS_MASK;
  wire wr_ctrl = wr & sel_ctrl;
  wire wr_flag = wr & sel_flag & avs_byteenable[0];
  wire wr_mask = wr & sel_mask & avs_byteenable[0];
  wire rd_status = rd & sel_status;
  wire [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire peripheral_irq_enable = ctrl_q[BIT_PERIPHERAL_IRQ_ENABLE];
  wire global_irq_enable = ctrl_q[BIT_GIE];

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata = rdata_q;

  // ****************************************
  // Per comparator edge and flag logic
  // ****************************************
  logic [NUM_CMP-1:0] s1_q, s2_q, s3_q;
  logic [NUM_CMP-1:0] cmp_sync_q;
  logic [NUM_CMP-1:0] out_prev_q;
  logic [NUM_CMP-1:0] out_now;
  logic [NUM_CMP-1:0] rise_ev, fall_ev, set_ev, req_ok, flag_d;

  // A bit moves on only while the last two stages agree
  wire [NUM_CMP-1:0] sync_agree = ~(s2_q ^ s3_q);
  wire [NUM_CMP-1:0] cmp_sync_d = (sync_agree & s3_q) | (~sync_agree & cmp_sync_q);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
      wire on = ctrl_q[gi*CTL_STRIDE+BIT_ON];
      wire pol = ctrl_q[gi*CTL_STRIDE+BIT_POL];
      wire rise_en = ctrl_q[gi*CTL_STRIDE+BIT_RISE];
      wire fall_en = ctrl_q[gi*CTL_STRIDE+BIT_FALL];
      wire ie = ctrl_q[gi*CTL_STRIDE+BIT_IE];
      // Off forces output low, so on/off toggles make edges; polarity toggles do so only while on
      assign out_now[gi] = on & (cmp_sync_q[gi] ^ pol); // see R6
      assign rise_ev[gi] = out_now[gi] & ~out_prev_q[gi]; // see R1
      assign fall_ev[gi] = ~out_now[gi] & out_prev_q[gi]; // see R1
      assign set_ev[gi] = (rise_ev[gi] & rise_en) | (fall_ev[gi] & fall_en); // see R2
      // Set beats clear; only a software write of one clears
      assign flag_d[gi] = set_ev[gi] |
                          (flag_q[gi] & ~(wr_flag & avs_writedata[gi])); // see R4, R5
      assign req_ok[gi] = flag_q[gi] & on & ie & (rise_en | fall_en); // see R3
    end
  endgenerate

  // ****************************************
  // Synchroniser and state
  // ****************************************
  // Change counts once second and third stages agree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      cmp_sync_q <= '0;
    end else if (clk_en) begin
      s1_q <= cmp_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      cmp_sync_q <= cmp_sync_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_prev_q <= '0;
      flag_q <= FLAG_RST;
      cmp_out <= '0;
    end else if (clk_en) begin
      out_prev_q <= out_now; // see R7
      flag_q <= flag_d;
      cmp_out <= out_now;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      mask_q <= MASK_RST;
      ack_q <= 1'b0;
    end else if (clk_en) begin
      ack_q <= req & ~ack_q;
      if (wr_ctrl) begin
        ctrl_q <= (ctrl_q & ~wmask) | (avs_writedata & wmask);
      end
      if (wr_mask) begin
        mask_q <= avs_writedata[NUM_CMP-1:0];
      end
    end
  end

  // ****************************************
  // Interrupt status, clear on read
  // ****************************************
  // Event in the read cycle survives the clear
  // Only bits that the read returned are cleared, so none is lost unseen
  wire [NUM_CMP-1:0] status_clr = {NUM_CMP{rd_status}} & rdata_q[NUM_CMP-1:0];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
    end else if (clk_en) begin
      status_q <= set_ev | (status_q & ~status_clr);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (clk_en && req && !ack_q) begin
      rdata_q <= '0;
      if (avs_read) begin
        case (1'b1)
          sel_ctrl: rdata_q <= ctrl_q;
          sel_flag: rdata_q <= {30'h0, flag_q};
          sel_status: rdata_q <= {30'h0, status_q};
          sel_mask: rdata_q <= {30'h0, mask_q};
          default: rdata_q <= '0;
        endcase
      end
    end
  end

  assign cmp_irq_req = |req_ok & peripheral_irq_enable & global_irq_enable; // see R3
  assign irq = |(status_q & mask_q);

  // ****************************************
  // Edge detection checks
  // ****************************************
  chk_detect_both: assert property (@(posedge clock) disable iff (!rst_n) // see R1
    clk_en && $changed(out_now[0]) |-> rise_ev[0] || fall_ev[0])
    else $error("change not detected");

  chk_detect_both1: assert property (@(posedge clock) disable iff (!rst_n) // see R1
    clk_en && $changed(out_now[1]) |-> rise_ev[1] || fall_ev[1])
    else $error("change not detected on second comparator");

  chk_edge_pulse: assert property (@(posedge clock) disable iff (!rst_n) // see R7
    clk_en && rise_ev[0] |=> !rise_ev[0])
    else $error("edge pulse longer than one cycle");

  chk_edge_pulse1: assert property (@(posedge clock) disable iff (!rst_n) // see R7
    clk_en && rise_ev[1] |=> !rise_ev[1])
    else $error("second rising pulse longer than one cycle");

  chk_fall_pulse: assert property (@(posedge clock) disable iff (!rst_n) // see R7
    clk_en && fall_ev[0] |=> !fall_ev[0])
    else $error("falling pulse longer than one cycle");

  chk_fall_pulse1: assert property (@(posedge clock) disable iff (!rst_n) // see R7
    clk_en && fall_ev[1] |=> !fall_ev[1])
    else $error("second falling pulse longer than one cycle");

  // A glitch that never settles across two stages must not reach the detector
  chk_sync_agrees: assert property (@(posedge clock) disable iff (!rst_n) // see R7
    $changed(cmp_sync_q[0]) |-> $past(s2_q[0]) == $past(s3_q[0]) && $past(clk_en))
    else $error("synchroniser passed a disagreeing bit");

  chk_sync_agrees1: assert property (@(posedge clock) disable iff (!rst_n) // see R7
    $changed(cmp_sync_q[1]) |-> $past(s2_q[1]) == $past(s3_q[1]) && $past(clk_en))
    else $error("second synchroniser passed a disagreeing bit");

  chk_off_drops: assert property (@(posedge clock) disable iff (!rst_n) // see R6
    !ctrl_q[BIT_ON] |-> !out_now[0])
    else $error("off comparator drives output");

  chk_off_drops1: assert property (@(posedge clock) disable iff (!rst_n) // see R6
    !ctrl_q[CTL_STRIDE+BIT_ON] |-> !out_now[1])
    else $error("off second comparator drives output");

  // ****************************************
  // Flag checks
  // ****************************************
  chk_rise_sets_flag: assert property (@(posedge clock) disable iff (!rst_n) // see R2
    clk_en && rise_ev[0] && ctrl_q[BIT_RISE] |=> flag_q[0])
    else $error("rising edge did not set flag");

  chk_rise_sets_flag1: assert property (@(posedge clock) disable iff (!rst_n) // see R2
    clk_en && rise_ev[1] && ctrl_q[CTL_STRIDE+BIT_RISE] |=> flag_q[1])
    else $error("second rising edge did not set flag");

  chk_fall_sets_flag: assert property (@(posedge clock) disable iff (!rst_n) // see R2
    clk_en && fall_ev[1] && ctrl_q[CTL_STRIDE+BIT_FALL] |=> flag_q[1])
    else $error("falling edge did not set flag");

  chk_fall_sets_flag0: assert property (@(posedge clock) disable iff (!rst_n) // see R2
    clk_en && fall_ev[0] && ctrl_q[BIT_FALL] |=> flag_q[0])
    else $error("first falling edge did not set flag");

  chk_no_edge_no_set: assert property (@(posedge clock) disable iff (!rst_n) // see R2
    !set_ev[0] && !flag_q[0] |=> !flag_q[0])
    else $error("flag set without enabled edge");

  chk_no_edge_no_set1: assert property (@(posedge clock) disable iff (!rst_n) // see R2
    !set_ev[1] && !flag_q[1] |=> !flag_q[1])
    else $error("second flag set without enabled edge");

  chk_flag_hold: assert property (@(posedge clock) disable iff (!rst_n) // see R4
    flag_q[0] && !(wr_flag && avs_writedata[0]) |=> flag_q[0])
    else $error("flag cleared without software");

  chk_flag_hold1: assert property (@(posedge clock) disable iff (!rst_n) // see R4
    flag_q[1] && !(wr_flag && avs_writedata[1]) |=> flag_q[1])
    else $error("second flag cleared without software");

  chk_clear_works: assert property (@(posedge clock) disable iff (!rst_n) // see R4
    wr_flag && avs_writedata[0] && !set_ev[0] |=> !flag_q[0])
    else $error("software clear had no effect");

  chk_clear_works1: assert property (@(posedge clock) disable iff (!rst_n) // see R4
    wr_flag && avs_writedata[1] && !set_ev[1] |=> !flag_q[1])
    else $error("second software clear had no effect");

  chk_set_beats_clr: assert property (@(posedge clock) disable iff (!rst_n) // see R5
    clk_en && set_ev[0] && wr_flag |=> flag_q[0])
    else $error("clear won over set");

  chk_set_beats_clr1: assert property (@(posedge clock) disable iff (!rst_n) // see R5
    clk_en && set_ev[1] && wr_flag |=> flag_q[1])
    else $error("second clear won over set");

  // ****************************************
  // Request, status and bus checks
  // ****************************************
  chk_req_gated: assert property (@(posedge clock) disable iff (!rst_n) // see R3
    cmp_irq_req |-> global_irq_enable && peripheral_irq_enable && |flag_q)
    else $error("request without enables");

  chk_req_needs_on: assert property (@(posedge clock) disable iff (!rst_n) // see R3
    cmp_irq_req |-> (flag_q[0] && ctrl_q[BIT_ON] && ctrl_q[BIT_IE]) ||
      (flag_q[1] && ctrl_q[CTL_STRIDE+BIT_ON] && ctrl_q[CTL_STRIDE+BIT_IE]))
    else $error("request from an off or unenabled comparator");

  chk_req_raised: assert property (@(posedge clock) disable iff (!rst_n) // see R3
    global_irq_enable && peripheral_irq_enable && flag_q[0] && ctrl_q[BIT_ON] && ctrl_q[BIT_IE] &&
      (ctrl_q[BIT_RISE] || ctrl_q[BIT_FALL]) |-> cmp_irq_req)
    else $error("enabled flag gave no request");

  chk_req_raised1: assert property (@(posedge clock) disable iff (!rst_n) // see R3
    global_irq_enable && peripheral_irq_enable && flag_q[1] && ctrl_q[CTL_STRIDE+BIT_ON] && ctrl_q[CTL_STRIDE+BIT_IE] &&
      (ctrl_q[CTL_STRIDE+BIT_RISE] || ctrl_q[CTL_STRIDE+BIT_FALL]) |-> cmp_irq_req)
    else $error("second enabled flag gave no request");

  chk_status_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    status_q[0] && !rd_status |=> status_q[0])
    else $error("status bit dropped without a read");

  chk_status_set: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && set_ev[0] |=> status_q[0])
    else $error("event did not set status");

  chk_read_clears: assert property (@(posedge clock) disable iff (!rst_n)
    rd_status && rdata_q[0] && !set_ev[0] |=> !status_q[0])
    else $error("status read did not clear");

  chk_one_wait_state: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && avs_waitrequest |=> !avs_waitrequest || !(avs_read || avs_write))
    else $error("bus wait longer than one cycle");

endmodule

/* File: verification/cei_comparator_model.sv */
`timescale 1ns/1ps
module cei_comparator_model (
  input wire logic clock,
  input wire logic [1:0] target,
  input wire logic [3:0] lag,
  output logic [1:0] cmp_raw
);
  int n;
  // Analog side settles after a variable lag, off the clock edge
  initial begin
    cmp_raw = 2'h0;
    forever begin
      @(posedge clock);
      if (target != cmp_raw) begin
        // At least one falling edge, so a change never meets a sampling edge
        for (n = 0; n <= lag; n++) @(negedge clock);
        cmp_raw = target;
      end
    end
  end
endmodule

/* File: verification/comparator_edge_interrupt_bench.sv */
`timescale 1ns/1ps
module comparator_edge_interrupt_bench;
  import cei_pkg::*;
  logic clock, rst_n, rd, wr, wreq, req, irq, cen;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdat, rdo, rdat, seed;
  logic [1:0] tgt, raw_w, cmp_out;
  logic [3:0] lag;
  int num_errors, total_checks, ctl, raw, flg, sts, msk, k, w;
  cei_comparator_model i_cmp (.clock(clock), .target(tgt), .lag(lag), .cmp_raw(raw_w));
  cei_comparator_edge_interrupt i_dut (.clock(clock), .rst_n(rst_n), .clk_en(cen),
    .cmp_raw(raw_w), .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_byteenable(4'hf), .avs_readdata(rdo), .avs_waitrequest(wreq), .cmp_out(cmp_out),
    .cmp_irq_req(req), .irq(irq));
  // ****************************************
  // Reference model
  // ****************************************
  function int det(int c, int r);
    det = 0;
    for (int i = 0; i < 2; i++) det |= ((c >> (8 * i)) & ((r >> i) ^ (c >> (8 * i + 1))) & 1) << i;
  endfunction
  function int exp_req();
    exp_req = 0;
    for (int i = 0; i < 2; i++) begin
      if ((flg >> i & 1) && (ctl >> (8 * i) & 1) && (ctl >> (8 * i) & 16) &&
          (ctl >> (8 * i) & 12))
        exp_req = 1;
    end
    exp_req &= (ctl >> 16) & (ctl >> 17) & 1;
  endfunction
  function logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task edges(int o, int n);
    for (int i = 0; i < 2; i++) begin
      if (((~o & n) >> i & 1) && (ctl >> (8 * i + 2) & 1) ||
          ((o & ~n) >> i & 1) && (ctl >> (8 * i + 3) & 1)) begin
        flg |= 1 << i;
        sts |= 1 << i;
      end
    end
  endtask
  // ****************************************
  // Bus and checks
  // ****************************************
  task complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(logic [31:0] got, int exp, string what);
    total_checks++;
    if (got !== exp[31:0]) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task bus(logic wt, logic [3:0] a, logic [31:0] d);
    int t;
    @(posedge clock);
    rd <= !wt; wr <= wt; addr <= a; wdat <= d;
    for (t = 0; t < 20; t++) begin
      @(posedge clock);
      if (wreq === 1'b0) break;
    end
    if (t == 20) begin
      num_errors++;
      complete_run();
    end
    rdat = rdo; rd <= 1'b0; wr <= 1'b0;
  endtask
  task check_all();
    bus(0, OFS_FLAG, 0);
    chk(rdat, flg, "flag");
    chk(cmp_out, det(ctl, raw), "out");
    chk(req, exp_req(), "request");
    chk(irq, |(sts & msk), "irq");
    bus(0, OFS_STATUS, 0);
    chk(rdat, sts, "status");
    sts = 0;
  endtask
  task step(int nc, int nr);
    int o, m;
    o = det(ctl, raw);
    ctl = nc;
    m = det(ctl, raw);
    bus(1, OFS_CTRL, nc);
    edges(o, m);
    repeat (24) @(posedge clock);
    raw = nr;
    tgt <= nr[1:0]; lag <= nxt() & 15;
    repeat (24) @(posedge clock);
    edges(m, det(ctl, raw));
    check_all();
  endtask
  task race(int nr);
    int o;
    o = det(ctl, raw);
    raw = nr;
    tgt <= nr[1:0];
    lag <= 4'h0;
    // Clear is timed to land on the edge that reaches the flag
    repeat (3) @(posedge clock);
    bus(1, OFS_FLAG, 3);
    flg = 0;
    repeat (24) @(posedge clock);
    edges(o, det(ctl, raw));
    check_all();
  endtask
  task freeze(int nr);
    int o;
    o = det(ctl, raw);
    raw = nr;
    cen <= 1'b0;
    tgt <= nr[1:0];
    lag <= 4'h3;
    repeat (24) @(posedge clock);
    chk(cmp_out, o, "frozen output");
    cen <= 1'b1;
    repeat (24) @(posedge clock);
    edges(o, det(ctl, raw));
    check_all();
  endtask
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    rst_n = 0; rd = 0; wr = 0; addr = 0; wdat = 0; tgt = 0; lag = 0; seed = 32'h0001_75b9;
    cen = 1'b1;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    bus(1, 4'h2, nxt());
    for (int i = 0; i < 5; i++) begin
      bus(0, (i < 4) ? 4'(4 * i) : 4'h2, 0);
      chk(rdat, 0, "reset value");
    end
    $display("test reset done");
    msk = nxt() & 3;
    bus(1, OFS_MASK, msk);
    step(32'h0003_001d, 1);
    race(0);
    freeze(1);
    step(32'h0003_001f, 1);
    step(32'h0003_001e, 1);
    $display("test directed done");
    for (k = 0; k < 12; k++) begin
      step(nxt() & 32'h0003_1f1f, nxt() & 3);
      w = nxt() & 3;
      bus(1, OFS_FLAG, w);
      flg &= ~w;
      msk = nxt() & 3;
      bus(1, OFS_MASK, msk);
      check_all();
    end
    $display("test random done");
    complete_run();
  end
endmodule
